/* inc/ps_config_consts.vh */
`ifndef PS_CONFIG_CONSTS_VH
`define PS_CONFIG_CONSTS_VH

// system clock rate
`define MCLK_MHZ 100

// power-on reset length
`define T_POR_NS 5000
`define POR_CYC ((`T_POR_NS * `MCLK_MHZ) / 1000)

// own status low pulse: 10 us least, 40 us most, 20 us used
`define T_STATUS_MIN_NS 10000
`define T_STATUS_MAX_NS 40000
`define T_STATUS_NS 20000
`define STATUS_CYC ((`T_STATUS_NS * `MCLK_MHZ) / 1000)

// start-up delay on the internal oscillator: 2 us least, 8 us most
`define T_CD2UM_MIN_NS 2000
`define T_CD2UM_MAX_NS 8000
`define T_CD2UM_NS 5000
`define CD2UM_CYC ((`T_CD2UM_NS * `MCLK_MHZ) / 1000)

// start-up delay on the user clock, in its periods
`define USER_CLK_PERIODS 40

// widths and depths
`define CNT_W 12
`define BYTE_W 8
`define FIFO_DEPTH 4
`define FIFO_AW 2

`endif

/* hw/pin_sync.v */
`timescale 1ns/1ps
module pin_sync #(
  parameter [0:0] INIT = 1'b1
) (
  // clock and reset
  input wire mclk,
  input wire rst_b,
  // raw pin
  input wire pinIn,
  // filtered level and its edges
  output reg level,
  output reg rise,
  output reg fall
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  // three stages; only s2 reads s1, a change counts once s2 and s3 agree
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      level <= INIT;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      rise <= (s2_q == s3_q) && s3_q && !level;
      fall <= (s2_q == s3_q) && !s3_q && level;
      if (s2_q == s3_q) begin
        level <= s3_q;
      end
    end
  end

endmodule

/* hw/byte_fifo.v */
`timescale 1ns/1ps
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // clock and reset
  input wire mclk,
  input wire rst_b,
  input wire clear,
  // fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // drain side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wrPtr_q;
  reg [AW:0] rdPtr_q;
  wire full;
  wire empty;
  wire doWrite;
  wire doRead;

  // extra pointer bit tells full from empty
  assign empty = (wrPtr_q == rdPtr_q);
  assign full = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rdPtr_q[AW-1:0]];
  assign doWrite = inValid && !full;
  assign doRead = outReady && !empty;

  // storage has no reset, only the pointers do
  always @(posedge mclk) begin
    if (doWrite) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  // pointers
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_q <= {(AW+1){1'b0}};
      rdPtr_q <= {(AW+1){1'b0}};
    end else if (clear) begin
      wrPtr_q <= {(AW+1){1'b0}};
      rdPtr_q <= {(AW+1){1'b0}};
    end else begin
      if (doWrite) begin
        wrPtr_q <= wrPtr_q + {{AW{1'b0}}, 1'b1};
      end
      if (doRead) begin
        rdPtr_q <= rdPtr_q + {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule

/* hw/ps_config_port.v */
`timescale 1ns/1ps
`include "ps_config_consts.vh"
module ps_config_port (
  // clock and reset
  input wire mclk,
  input wire rst_b,
  // host configuration pins
  input wire cfgRequestN,
  input wire cfgClockPin,
  input wire serialLoadBit,
  // open-drain status line
  input wire statusIn,
  output reg statusOut,
  output reg statusOe,
  // open-drain configuration-done line
  input wire confDoneIn,
  output reg confDoneOut,
  output reg confDoneOe,
  // chain enables
  input wire chainEnableInN,
  output reg chainEnableOutN,
  // start-up options
  input wire userStartupClock,
  input wire useUserClock,
  input wire cableMode,
  input wire autoRestart,
  // configuration core side
  output reg [`BYTE_W-1:0] loadData,
  output reg loadValid,
  input wire loadReady,
  input wire loadDone,
  input wire loadError,
  // device mode
  output reg userMode,
  output reg ioTristate
);

  ////////////////////////////////////////////////////////////////////////////
  // constants

  localparam [2:0] ST_POR = 3'b000;
  localparam [2:0] ST_RESET = 3'b001;
  localparam [2:0] ST_CONFIG = 3'b010;
  localparam [2:0] ST_ERROR = 3'b011;
  localparam [2:0] ST_HALT = 3'b100;
  localparam [2:0] ST_INIT = 3'b101;
  localparam [2:0] ST_USER = 3'b110;

  // end counts are worked out at integer width first, then cut to the
  // counter width on purpose; every one of them fits in CNT_W bits
  localparam integer POR_END = `POR_CYC - 1;
  localparam integer STATUS_END = `STATUS_CYC - 1;
  localparam integer CD2UM_END = `CD2UM_CYC - 1;
  localparam integer USER_END = `USER_CLK_PERIODS - 1;

  localparam [`CNT_W-1:0] POR_LAST = POR_END[`CNT_W-1:0];
  localparam [`CNT_W-1:0] STATUS_LAST = STATUS_END[`CNT_W-1:0];
  localparam [`CNT_W-1:0] CD2UM_LAST = CD2UM_END[`CNT_W-1:0];
  localparam [`CNT_W-1:0] USER_LAST = USER_END[`CNT_W-1:0];
  localparam [`CNT_W-1:0] CNT_ONE = {{(`CNT_W-1){1'b0}}, 1'b1};

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  // synchronised levels and edges of the pins
  wire reqLvl;
  wire dclkRise;
  wire dataLvl;
  wire statusLvl;
  wire confDoneLvl;
  wire chainEnLvl;
  wire userClkRise;

  // request line, released high by its pull-up at power-up
  pin_sync #(.INIT(1'b1)) u_syncReq (
    .mclk(mclk), .rst_b(rst_b), .pinIn(cfgRequestN),
    .level(reqLvl), .rise(), .fall()
  );

  // link clock is sampled, only its rising edges matter
  pin_sync #(.INIT(1'b0)) u_syncClk (
    .mclk(mclk), .rst_b(rst_b), .pinIn(cfgClockPin),
    .level(), .rise(dclkRise), .fall()
  );

  // data takes the same delay as the clock so both stay aligned
  pin_sync #(.INIT(1'b0)) u_syncData (
    .mclk(mclk), .rst_b(rst_b), .pinIn(serialLoadBit),
    .level(dataLvl), .rise(), .fall()
  );

  // shared status line, low while anyone holds it
  pin_sync #(.INIT(1'b0)) u_syncStatus (
    .mclk(mclk), .rst_b(rst_b), .pinIn(statusIn),
    .level(statusLvl), .rise(), .fall()
  );

  // shared done line, high only once every device has released it
  pin_sync #(.INIT(1'b0)) u_syncDone (
    .mclk(mclk), .rst_b(rst_b), .pinIn(confDoneIn),
    .level(confDoneLvl), .rise(), .fall()
  );

  // chain enable from the previous device
  pin_sync #(.INIT(1'b1)) u_syncChain (
    .mclk(mclk), .rst_b(rst_b), .pinIn(chainEnableInN),
    .level(chainEnLvl), .rise(), .fall()
  );

  // optional user start-up clock
  pin_sync #(.INIT(1'b0)) u_syncUser (
    .mclk(mclk), .rst_b(rst_b), .pinIn(userStartupClock),
    .level(), .rise(userClkRise), .fall()
  );

  ////////////////////////////////////////////////////////////////////////////
  // state and bit capture registers

  // sequencer state, one shared counter and the bit assembly
  reg [2:0] state_q;
  reg [`CNT_W-1:0] cnt_q;
  reg [`BYTE_W-1:0] shift_q;
  reg [2:0] bitCnt_q;
  reg [`BYTE_W-1:0] pendData_q;
  reg pendValid_q;

  // hand-off nets between capture, holding stage and buffer
  wire pendReady;
  wire fifoValid;
  wire fifoTake;
  wire [`BYTE_W-1:0] fifoData;
  wire capture;
  wire byteDone;
  wire overflow;
  wire userClkSel;
  wire inReset;

  // bits are only taken while loading and while this device is enabled
  assign capture = (state_q == ST_CONFIG) && !chainEnLvl && dclkRise;
  assign byteDone = capture && (bitCnt_q == 3'h7);
  // no handshake exists on the link, so a full path can only be an error
  assign overflow = byteDone && pendValid_q && !pendReady;
  // the cable clears the user clock option, the internal oscillator runs
  assign userClkSel = useUserClock && !cableMode;
  assign inReset = (state_q == ST_POR) || (state_q == ST_RESET);

  ////////////////////////////////////////////////////////////////////////////
  // configuration sequencer

  // normal path is POR, RESET, CONFIG, INIT, USER; the request test sits ahead
  // of the case so a low request forces RESET from every state but POR, and
  // a low shared status wire sends CONFIG or INIT back to RESET as well
  // an own error runs one bounded status pulse in ERROR, then RESET when auto
  // restart may act, HALT otherwise; the cable host always ends up in HALT
  // trade-off: one shared counter serves POR, ERROR and INIT, never two at once
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_POR;
      cnt_q <= {`CNT_W{1'b0}};
      statusOe <= 1'b1;
      confDoneOe <= 1'b1;
      chainEnableOutN <= 1'b1;
      userMode <= 1'b0;
      ioTristate <= 1'b1;
    end else if (state_q != ST_POR && !reqLvl) begin
      // request low: pull both lines low and drop back to reset
      state_q <= ST_RESET;
      cnt_q <= {`CNT_W{1'b0}};
      statusOe <= 1'b1;
      confDoneOe <= 1'b1;
      chainEnableOutN <= 1'b1;
      userMode <= 1'b0;
      ioTristate <= 1'b1;
    end else begin
      case (state_q)
        ST_POR: begin
          // hold status low and outputs floating for the power-on time
          statusOe <= 1'b1;
          ioTristate <= 1'b1;
          if (cnt_q == POR_LAST) begin
            cnt_q <= {`CNT_W{1'b0}};
            state_q <= ST_RESET;
          end else begin
            cnt_q <= cnt_q + CNT_ONE;
          end
        end
        ST_RESET: begin
          // request is high here, so let go of status at once
          statusOe <= 1'b0;
          confDoneOe <= 1'b1;
          chainEnableOutN <= 1'b1; // halted chain: next device disabled
          if (statusLvl) begin
            state_q <= ST_CONFIG;
          end
        end
        ST_CONFIG: begin
          if (!statusLvl) begin
            // another device flagged an error on the shared line
            state_q <= ST_RESET;
          end else if (loadError || overflow) begin
            state_q <= ST_ERROR;
            statusOe <= 1'b1;
            cnt_q <= {`CNT_W{1'b0}};
          end else if (loadDone) begin
            state_q <= ST_INIT;
            confDoneOe <= 1'b0;
            chainEnableOutN <= 1'b0;
            cnt_q <= {`CNT_W{1'b0}};
          end
        end
        ST_ERROR: begin
          // bounded low pulse, then restart only if allowed
          if (cnt_q == STATUS_LAST) begin
            statusOe <= 1'b0;
            cnt_q <= {`CNT_W{1'b0}};
            if (autoRestart && !cableMode) begin
              state_q <= ST_RESET;
            end else begin
              state_q <= ST_HALT;
            end
          end else begin
            cnt_q <= cnt_q + CNT_ONE;
          end
        end
        ST_HALT: begin
          // waits for the host to pulse the request line
          statusOe <= 1'b0;
        end
        ST_INIT: begin
          if (!statusLvl) begin
            state_q <= ST_RESET;
          end else if (!confDoneLvl) begin
            // the shared done line is still held by another device
            cnt_q <= {`CNT_W{1'b0}};
          end else if (userClkSel) begin
            if (userClkRise) begin
              if (cnt_q == USER_LAST) begin
                state_q <= ST_USER;
                userMode <= 1'b1;
                ioTristate <= 1'b0;
              end else begin
                cnt_q <= cnt_q + CNT_ONE;
              end
            end
          end else if (cnt_q == CD2UM_LAST) begin
            state_q <= ST_USER;
            userMode <= 1'b1;
            ioTristate <= 1'b0;
          end else begin
            cnt_q <= cnt_q + CNT_ONE;
          end
        end
        ST_USER: begin
          // held until the request line falls
          userMode <= 1'b1;
          ioTristate <= 1'b0;
        end
        default: begin
          // unused codes restart from power-on
          state_q <= ST_POR;
          cnt_q <= {`CNT_W{1'b0}};
        end
      endcase
    end
  end

  // open-drain lines only ever pull low
  // the level seen on the wire comes back through statusIn and confDoneIn
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      statusOut <= 1'b0;
      confDoneOut <= 1'b0;
    end else begin
      statusOut <= 1'b0;
      confDoneOut <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial to byte assembly

  // lsb arrives first; anything half-shifted is dropped outside loading
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      shift_q <= {`BYTE_W{1'b0}};
      bitCnt_q <= 3'h0;
    end else if (state_q != ST_CONFIG) begin
      bitCnt_q <= 3'h0;
    end else if (capture) begin
      shift_q <= {dataLvl, shift_q[`BYTE_W-1:1]};
      bitCnt_q <= bitCnt_q + 3'h1;
    end
  end

  // one-byte holding stage; a new byte wins over a hand-off in the same cycle
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pendData_q <= {`BYTE_W{1'b0}};
      pendValid_q <= 1'b0;
    end else if (inReset) begin
      pendValid_q <= 1'b0;
    end else if (byteDone && !overflow) begin
      pendData_q <= {dataLvl, shift_q[`BYTE_W-1:1]};
      pendValid_q <= 1'b1;
    end else if (pendReady) begin
      pendValid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data buffer toward the configuration core

  // four bytes of slack cover core stalls; the link itself cannot wait
  byte_fifo #(.WIDTH(`BYTE_W), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .clear(inReset),
    .inValid(pendValid_q),
    .inReady(pendReady),
    .inData(pendData_q),
    .outValid(fifoValid),
    .outReady(fifoTake),
    .outData(fifoData)
  );

  // registered output stage so the core sees flop outputs only
  assign fifoTake = !loadValid || loadReady;

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      loadData <= {`BYTE_W{1'b0}};
      loadValid <= 1'b0;
    end else if (inReset) begin
      loadValid <= 1'b0;
    end else if (fifoTake) begin
      loadValid <= fifoValid;
      if (fifoValid) begin
        loadData <= fifoData;
      end
    end
  end

endmodule

/* verif/ps_config_port_sva.sv */
`timescale 1ns/1ps
module ps_config_port_sva (
  // clock and reset
  input wire mclk,
  input wire rst_b,
  // pins and options
  input wire cfgRequestN,
  input wire confDoneIn,
  input wire userStartupClock,
  input wire useUserClock,
  input wire cableMode,
  input wire loadDone,
  // device outputs
  input wire statusOe,
  input wire confDoneOe,
  input wire chainEnableOutN,
  input wire userMode,
  input wire ioTristate
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  //////////////////////////////////////////////////////////////////////////////
  // time since reset, own status low time, done wire high time, user clock rises
  reg [9:0] upCnt_q;
  reg [12:0] lowCnt_q;
  reg [9:0] doneCnt_q;
  reg [5:0] ucCnt_q;
  reg ucPrev_q;
  wire porOver = upCnt_q > 10'h208;
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      upCnt_q <= 10'h000;
      lowCnt_q <= 13'h0000;
      doneCnt_q <= 10'h000;
      ucCnt_q <= 6'h00;
      ucPrev_q <= 1'b0;
    end else begin
      upCnt_q <= porOver ? upCnt_q : upCnt_q + 10'h001;
      lowCnt_q <= (statusOe && cfgRequestN && porOver) ? lowCnt_q + 13'h0001 : 13'h0000;
      doneCnt_q <= !confDoneIn ? 10'h000 : doneCnt_q + {9'h000, doneCnt_q != 10'h3ff};
      ucPrev_q <= userStartupClock;
      ucCnt_q <= !confDoneIn ? 6'h00 : ucCnt_q + {5'h00, userStartupClock && !ucPrev_q};
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // request edges against the open-drain answers
  a_done_fall_fast: assert property ($fell(cfgRequestN) |-> ##[1:20] confDoneOe)
    else $error("done not pulled low after request fall");
  a_status_fall_fast: assert property ($fell(cfgRequestN) |-> ##[1:20] statusOe)
    else $error("status not pulled low after request fall");
  a_status_release: assert property ($rose(cfgRequestN) && porOver |-> ##[1:100] !statusOe)
    else $error("status not released after request rise");
  // own status pulses: short request follow-ups are excluded by the 20 cycle floor
  a_pulse_max: assert property (lowCnt_q <= 13'h0fa0)
    else $error("status pulse too long");
  a_pulse_min: assert property ($fell(statusOe) && $past(lowCnt_q) > 13'h0014 |-> $past(lowCnt_q) >= 13'h03e8)
    else $error("status pulse too short");
  a_por_hold: assert property (!porOver && upCnt_q < 10'h1ea |-> statusOe && confDoneOe && ioTristate && !userMode)
    else $error("power-on hold broken");
  a_done_cause: assert property ($fell(confDoneOe) |-> $past(loadDone))
    else $error("done released without load end");
  a_chain_pass: assert property ($fell(chainEnableOutN) |-> $past(loadDone) && !confDoneOe)
    else $error("chain enable passed early");
  a_reset_hold: assert property (!cfgRequestN [*8] |-> !userMode && ioTristate && statusOe && confDoneOe)
    else $error("not in reset while request low");
  a_start_internal: assert property ($rose(userMode) && !(useUserClock && !cableMode) |-> doneCnt_q >= 10'h0c8 && doneCnt_q <= 10'h320)
    else $error("internal start-up delay off");
  a_start_user: assert property ($rose(userMode) && useUserClock && !cableMode |-> ucCnt_q >= 6'h28 && ucCnt_q <= 6'h29)
    else $error("user clock start-up count off");
endmodule
bind ps_config_port ps_config_port_sva u_ps_config_port_sva (
  .mclk(mclk), .rst_b(rst_b), .cfgRequestN(cfgRequestN), .confDoneIn(confDoneIn),
  .userStartupClock(userStartupClock), .useUserClock(useUserClock), .cableMode(cableMode),
  .loadDone(loadDone), .statusOe(statusOe), .confDoneOe(confDoneOe),
  .chainEnableOutN(chainEnableOutN), .userMode(userMode), .ioTristate(ioTristate)
);

/* verif/ps_host_model.sv */
`timescale 1ns/1ps
module ps_host_model (
  // clock
  input wire mclk,
  // link pins
  output reg cfgRequestN,
  output reg cfgClockPin,
  output reg serialLoadBit,
  // board status wire
  input wire statusWire
);
  // idle: request high, clock parked low
  initial begin
    cfgRequestN = 1'b1;
    cfgClockPin = 1'b0;
    serialLoadBit = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // restart pulse, then wait for the released wire and the start margins
  task restart;
    integer k;
    begin
      @(posedge mclk);
      cfgRequestN <= 1'b0;
      repeat (800) @(posedge mclk);
      cfgRequestN <= 1'b1;
      k = 0;
      while (statusWire !== 1'b1 && k < 5000) begin
        @(posedge mclk);
        k = k + 1;
      end
      repeat (4000) @(posedge mclk);
    end
  endtask
  // one byte, bit 0 first, 160 ns per bit: 80 ns low, 80 ns high
  // clock stands still between frames
  task send_byte(input [7:0] b);
    integer n;
    begin
      for (n = 0; n < 8; n = n + 1) begin
        @(posedge mclk);
        serialLoadBit <= b[n];
        repeat (7) @(posedge mclk);
        cfgClockPin <= 1'b1;
        repeat (8) @(posedge mclk);
        cfgClockPin <= 1'b0;
        serialLoadBit <= ~b[n]; // zero hold: old bit gone, line still driven
      end
    end
  endtask
endmodule

/* verif/tb_ps_config_port.sv */
`timescale 1ns/1ps
module tb_ps_config_port;
  reg mclk = 1'b0;
  reg rst_b = 1'b0;
  reg chainEnableInN = 1'b0, userStartupClock = 1'b0, useUserClock = 1'b0;
  reg cableMode = 1'b0, autoRestart = 1'b0, loadDone = 1'b0, loadError = 1'b0;
  reg extStatusLow = 1'b0, extDoneLow = 1'b0, ucRun = 1'b0, rdyRand = 1'b0;
  reg rdyFix = 1'b1, rdyBit = 1'b1;
  reg [3:0] ucDiv = 4'h0;
  wire cfgRequestN, cfgClockPin, serialLoadBit, statusOut, statusOe, confDoneOut, confDoneOe;
  wire chainEnableOutN, loadValid, userMode, ioTristate;
  wire [7:0] loadData;
  wire loadReady = rdyRand ? rdyBit : rdyFix;
  // pull-ups on both shared wires; other chain members may hold them low
  wire statusWire = !((statusOe && !statusOut) || extStatusLow);
  wire doneWire = !((confDoneOe && !confDoneOut) || extDoneLow);
  integer error_cnt = 0, n_checks = 0;
  reg [7:0] got[$];
  reg [7:0] sent[$];
  //////////////////////////////////////////////////////////////////////////////
  ps_config_port u_ps_config_port (
    .mclk(mclk), .rst_b(rst_b), .cfgRequestN(cfgRequestN), .cfgClockPin(cfgClockPin),
    .serialLoadBit(serialLoadBit), .statusIn(statusWire), .statusOut(statusOut),
    .statusOe(statusOe), .confDoneIn(doneWire), .confDoneOut(confDoneOut),
    .confDoneOe(confDoneOe), .chainEnableInN(chainEnableInN),
    .chainEnableOutN(chainEnableOutN), .userStartupClock(userStartupClock),
    .useUserClock(useUserClock), .cableMode(cableMode), .autoRestart(autoRestart),
    .loadData(loadData), .loadValid(loadValid), .loadReady(loadReady),
    .loadDone(loadDone), .loadError(loadError), .userMode(userMode), .ioTristate(ioTristate)
  );
  ps_host_model u_ps_host_model (
    .mclk(mclk), .cfgRequestN(cfgRequestN), .cfgClockPin(cfgClockPin),
    .serialLoadBit(serialLoadBit), .statusWire(statusWire)
  );
  //////////////////////////////////////////////////////////////////////////////
  always #5 mclk = ~mclk;
  // core side: random stalls, byte collection, user clock of 160 ns
  always @(posedge mclk) begin
    rdyBit <= $urandom % 2;
    ucDiv <= ucDiv + 4'h1;
    if (ucRun && ucDiv[2:0] == 3'h7) userStartupClock <= ~userStartupClock;
    if (loadValid === 1'b1 && loadReady === 1'b1) got.push_back(loadData);
  end
  task check(input logic ok, input string msg);
    begin
      n_checks++;
      if (ok !== 1'b1) begin
        error_cnt++;
        $display("[ERR] %0t %s", $time, msg);
      end
    end
  endtask
  task waitc(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  task tx(input integer n);
    reg [7:0] b;
    repeat (n) begin
      b = $urandom;
      sent.push_back(b);
      u_ps_host_model.send_byte(b);
    end
  endtask
  // bytes must arrive whole and in order
  task match;
    integer k;
    begin
      waitc(12);
      check(got.size() == sent.size(), "byte count");
      for (k = 0; k < sent.size() && k < got.size(); k++)
        check(got[k] === sent[k], "byte value");
      got.delete();
      sent.delete();
    end
  endtask
  task hit(input d, input e);
    begin
      loadDone <= d;
      loadError <= e;
      @(posedge mclk);
      loadDone <= 1'b0;
      loadError <= 1'b0;
    end
  endtask
  task restart;
    begin
      fork
        u_ps_host_model.restart();
        begin
          waitc(20);
          check(statusOe === 1'b1 && confDoneOe === 1'b1, "slow reset answer");
        end
      join
      check(statusOe === 1'b0 && userMode === 1'b0, "not configuring");
      got.delete();
      sent.delete();
    end
  endtask
  task finish_test;
    begin
      if (error_cnt == 0 && n_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // hang guard, well past the expected run
  initial begin
    #900000;
    error_cnt++;
    finish_test;
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(83));
    waitc(8);
    rst_b <= 1'b1;
    waitc(300);
    check(statusOe === 1'b1 && ioTristate === 1'b1, "power-on hold");
    waitc(300);
    restart();
    // fill while stalled, then drain; then random stalls
    rdyFix <= 1'b0;
    tx(6);
    check(statusOe === 1'b0 && loadValid === 1'b1, "fill refused");
    rdyFix <= 1'b1;
    match();
    rdyRand <= 1'b1;
    tx(8);
    rdyRand <= 1'b0;
    match();
    // chain enable off, then another member holding status low
    chainEnableInN <= 1'b1;
    tx(1);
    sent.delete();
    chainEnableInN <= 1'b0;
    extStatusLow <= 1'b1;
    tx(1);
    sent.delete();
    extStatusLow <= 1'b0;
    match();
    waitc(500);
    tx(1);
    match();
    // error with restart, then on the cable where restart has no effect
    autoRestart <= 1'b1;
    hit(1'b0, 1'b1);
    waitc(3);
    check(statusOe === 1'b1, "error pulse");
    waitc(2500);
    tx(1);
    match();
    cableMode <= 1'b1;
    hit(1'b1, 1'b1);
    waitc(2500);
    tx(1);
    sent.delete();
    match();
    autoRestart <= 1'b0;
    cableMode <= 1'b0;
    restart();
    // overflow of the stalled path
    rdyFix <= 1'b0;
    tx(8);
    check(statusOe === 1'b1, "overflow error");
    rdyFix <= 1'b1;
    restart();
    // done held low by a chain member, then internal start-up
    tx(2);
    match();
    extDoneLow <= 1'b1;
    hit(1'b1, 1'b0);
    waitc(2);
    check(confDoneOe === 1'b0 && chainEnableOutN === 1'b0, "done or chain");
    waitc(1000);
    check(userMode === 1'b0, "early user mode");
    extDoneLow <= 1'b0;
    waitc(600);
    check(userMode === 1'b1 && ioTristate === 1'b0, "no user mode");
    // start-up on the user clock, then cable mode ignoring it
    restart();
    useUserClock <= 1'b1;
    hit(1'b1, 1'b0);
    waitc(20);
    ucRun <= 1'b1;
    waitc(608);
    check(userMode === 1'b0, "user clock start early");
    waitc(80);
    check(userMode === 1'b1, "user clock start late");
    ucRun <= 1'b0;
    restart();
    cableMode <= 1'b1;
    hit(1'b1, 1'b0);
    waitc(600);
    check(userMode === 1'b1, "cable start-up");
    finish_test;
  end
endmodule
